// ---- shared/mbw_regs.svh ----
`ifndef MBW_REGS_SVH
`define MBW_REGS_SVH
// What this block does
// - low code 16 KB maps straight, unbanked
// - second code window uses upper-code bank
// - third window uses middle-window bank
// - top window aliases the upper-code bank window
// - xdata 0x4000 region goes on-chip; low goes SFR
// - isa io space reached via programmed io window
// - writing one clears a status bit
// - reading status leaves pending bits untouched
// - each status bit clears independently
// - usb traffic events drive interrupt line 0
// - second and third windows have their own bank registers; top shares the upper-code one

// ==========================================
// register offsets in xdata space
`define MBW_OFF_MID_BANK 16'h7f28
`define MBW_OFF_UPPER_BANK 16'h7f29
`define MBW_OFF_IRQ0_STATUS 16'h7f30
`define MBW_OFF_IO_BASE 16'h7f71
`define MBW_OFF_MEM_BASE 16'h7f72
// ==========================================
// reset values
`define MBW_RST_BANK 8'h00
`define MBW_RST_STATUS 8'h00
// ==========================================
// address fields
`define MBW_WIN_MSB 15
`define MBW_WIN_LSB 14
`define MBW_OFS_MSB 13
`define MBW_HI_LSB 8
`define MBW_NIB_LSB 12
`define MBW_IO_OFS_MSB 7
`define MBW_MEM_OFS_MSB 11
`define MBW_BANK_MSB 5
`define MBW_WIN_LOW 2'h0
`define MBW_WIN_SECOND 2'h1
`define MBW_WIN_THIRD 2'h2
`define MBW_WIN_TOP 2'h3
// io window 0x4000-0x40ff, memory window 0x5000-0x5fff, local block 0x7fxx
`define MBW_IO_HI 8'h40
`define MBW_MEM_NIB 4'h5
`define MBW_LOCAL_HI 8'h7f
`define MBW_FLASH_ZERO_HI 6'h00
`endif

// ---- shared/mbw_pkg.sv ----
package mbw_pkg;
   // one-hot selection of where an access lands
   typedef enum logic [6:0] {
      MBW_TGT_NONE = 7'h01,
      MBW_TGT_FLASH = 7'h02,
      MBW_TGT_SFR = 7'h04,
      MBW_TGT_PERIPH = 7'h08,
      MBW_TGT_IO = 7'h10,
      MBW_TGT_MEM = 7'h20,
      MBW_TGT_LOCAL = 7'h40
   } mbw_target_t;
endpackage

// ---- core/mbw_mapper.sv ----
`timescale 1ns/1ns
`include "mbw_regs.svh"
module mbw_mapper #(
   parameter int EVENT_W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic code_rd,
   input wire logic xdata_rd,
   input wire logic xdata_wr,
   input wire logic [15:0] core_addr,
   input wire logic [7:0] core_wdata,
   input wire logic [EVENT_W-1:0] usb_event,
   output logic access_valid,
   output logic access_write,
   output logic flash_sel,
   output logic [19:0] flash_addr,
   output logic sfr_sel,
   output logic periph_sel,
   output logic [15:0] periph_addr,
   output logic io_sel,
   output logic [15:0] io_addr,
   output logic mem_sel,
   output logic [19:0] mem_addr,
   output logic local_sel,
   output logic [7:0] local_rdata,
   output logic irq0
);
   // ==========================================
   // helpers

   // true when an xdata address hits a given local register
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   // banked flash address: six bank bits on top of the 14-bit offset
   function automatic logic [19:0] bank_addr(input logic [7:0] bank,
                                             input logic [15:0] a);
      bank_addr = {bank[`MBW_BANK_MSB:0], a[`MBW_OFS_MSB:0]};
   endfunction

   // ==========================================
   // local registers
   logic [7:0] mid_bank_q;
   logic [7:0] upper_bank_q;
   logic [7:0] io_base_q;
   logic io_base_set_q;
   logic [7:0] mem_base_q;
   logic [EVENT_W-1:0] status_q;
   logic [EVENT_W-1:0] status_d;

   // ==========================================
   // request decode
   wire logic req = code_rd | xdata_rd | xdata_wr;
   wire logic is_xdata = xdata_rd | xdata_wr;
   wire logic [1:0] win = core_addr[`MBW_WIN_MSB:`MBW_WIN_LSB];
   wire logic in_io = core_addr[`MBW_WIN_MSB:`MBW_HI_LSB] == `MBW_IO_HI;
   wire logic in_mem = core_addr[`MBW_WIN_MSB:`MBW_NIB_LSB] == `MBW_MEM_NIB;
   wire logic in_local = core_addr[`MBW_WIN_MSB:`MBW_HI_LSB] == `MBW_LOCAL_HI;

   // isa windows: the base register supplies the bits above the window offset
   wire logic [15:0] io_addr_d = {io_base_q, core_addr[`MBW_IO_OFS_MSB:0]};
   wire logic [19:0] mem_addr_d = {mem_base_q, core_addr[`MBW_MEM_OFS_MSB:0]};

   // the low window is a straight copy of flash zero page
   wire logic [19:0] low_addr = {`MBW_FLASH_ZERO_HI, core_addr[`MBW_OFS_MSB:0]};
   wire logic [19:0] second_addr = bank_addr(upper_bank_q, core_addr);
   wire logic [19:0] third_addr = bank_addr(mid_bank_q, core_addr);
   // top window reuses the upper-code bank, so both views see one location
   wire logic [19:0] top_addr = bank_addr(upper_bank_q, core_addr);

   // the flash address seen for this access, whatever its space
   wire logic [19:0] flash_addr_d = (win == `MBW_WIN_LOW) ? low_addr :
                                    (win == `MBW_WIN_SECOND) ? second_addr :
                                    (win == `MBW_WIN_THIRD) ? third_addr : top_addr;

   // xdata second window goes on-chip: io, memory, local registers, else peripherals
   wire mbw_pkg::mbw_target_t xdata_mid_tgt =
      (in_io && io_base_set_q) ? mbw_pkg::MBW_TGT_IO :
      in_io ? mbw_pkg::MBW_TGT_NONE :
      in_mem ? mbw_pkg::MBW_TGT_MEM :
      in_local ? mbw_pkg::MBW_TGT_LOCAL : mbw_pkg::MBW_TGT_PERIPH;

   // code space is flash everywhere; xdata carves out the two low windows
   wire mbw_pkg::mbw_target_t target_d =
      !req ? mbw_pkg::MBW_TGT_NONE :
      !is_xdata ? mbw_pkg::MBW_TGT_FLASH :
      (win == `MBW_WIN_LOW) ? mbw_pkg::MBW_TGT_SFR :
      (win == `MBW_WIN_SECOND) ? xdata_mid_tgt : mbw_pkg::MBW_TGT_FLASH;

   // ==========================================
   // register write decode
   // local registers live only in the 0x7fxx page of the second xdata window
   wire logic local_wr = xdata_wr && in_local && (win == `MBW_WIN_SECOND);
   wire logic local_rd = xdata_rd && in_local && (win == `MBW_WIN_SECOND);
   wire logic wr_mid = local_wr && hit(core_addr, `MBW_OFF_MID_BANK);
   wire logic wr_upper = local_wr && hit(core_addr, `MBW_OFF_UPPER_BANK);
   wire logic wr_io = local_wr && hit(core_addr, `MBW_OFF_IO_BASE);
   wire logic wr_mem = local_wr && hit(core_addr, `MBW_OFF_MEM_BASE);
   wire logic wr_status = local_wr && hit(core_addr, `MBW_OFF_IRQ0_STATUS);

   // read mux; unmapped local offsets read as zero
   wire logic [7:0] rdata_d =
      hit(core_addr, `MBW_OFF_MID_BANK) ? mid_bank_q :
      hit(core_addr, `MBW_OFF_UPPER_BANK) ? upper_bank_q :
      hit(core_addr, `MBW_OFF_IO_BASE) ? io_base_q :
      hit(core_addr, `MBW_OFF_MEM_BASE) ? mem_base_q :
      hit(core_addr, `MBW_OFF_IRQ0_STATUS) ? 8'(status_q) : `MBW_RST_BANK;

   // ==========================================
   // interrupt status
   // a read never touches the bits, so polling cannot drop an event
   // a set in the same cycle as its clear wins, so no event is lost
   // clearing a bit that is not pending is harmless
   wire logic [EVENT_W-1:0] clr_mask = wr_status ? core_wdata[EVENT_W-1:0] : '0;
   always_comb begin
      status_d = (status_q & ~clr_mask) | usb_event;
   end

   // ==========================================
   // bank and base registers; the top window shares the upper-code bank
   // the second and third windows keep their own banks so software can move them apart

   // middle window bank, third 16 KB of code and xdata
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mid_bank_q <= `MBW_RST_BANK;
      end else if (wr_mid) begin
         mid_bank_q <= core_wdata;
      end
   end

   // upper-code bank, shared by the second code window and its top alias
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_bank_q <= `MBW_RST_BANK;
      end else if (wr_upper) begin
         upper_bank_q <= core_wdata;
      end
   end

   // io window base; the window stays shut until the first write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         io_base_q <= `MBW_RST_BANK;
         io_base_set_q <= 1'b0;
      end else if (wr_io) begin
         io_base_q <= core_wdata;
         io_base_set_q <= 1'b1;
      end
   end

   // memory window base, eight bits above the 4 KB offset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_base_q <= `MBW_RST_BANK;
      end else if (wr_mem) begin
         mem_base_q <= core_wdata;
      end
   end

   // status bits take their next value every cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   // ==========================================
   // registered access outputs, valid one cycle after the request
   mbw_pkg::mbw_target_t target_q;

   // where the access landed, and whether it was a write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         target_q <= mbw_pkg::MBW_TGT_NONE;
         access_valid <= 1'b0;
         access_write <= 1'b0;
      end else begin
         target_q <= target_d;
         access_valid <= req;
         access_write <= xdata_wr;
      end
   end

   // addresses follow every cycle; they only mean something with their select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flash_addr <= '0;
         periph_addr <= '0;
         io_addr <= '0;
         mem_addr <= '0;
      end else begin
         flash_addr <= flash_addr_d;
         periph_addr <= core_addr;
         io_addr <= io_addr_d;
         mem_addr <= mem_addr_d;
      end
   end

   // read data holds until the next local read, so a late sampler still sees it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         local_rdata <= '0;
      end else if (local_rd) begin
         local_rdata <= rdata_d;
      end
   end

   // ==========================================
   // one-hot target fans out to the selects
   assign flash_sel = target_q == mbw_pkg::MBW_TGT_FLASH;
   assign sfr_sel = target_q == mbw_pkg::MBW_TGT_SFR;
   assign periph_sel = target_q == mbw_pkg::MBW_TGT_PERIPH;
   assign io_sel = target_q == mbw_pkg::MBW_TGT_IO;
   assign mem_sel = target_q == mbw_pkg::MBW_TGT_MEM;
   assign local_sel = target_q == mbw_pkg::MBW_TGT_LOCAL;
   // any pending usb traffic event holds line 0 up
   assign irq0 = |status_q;
endmodule

// ---- sim/mbw_map_checker.sv ----
`timescale 1ns/1ns
// ==========================================
// port checker, one cycle answer latency
module mbw_map_checker #(
   parameter int EVENT_W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic code_rd,
   input wire logic xdata_rd,
   input wire logic xdata_wr,
   input wire logic [15:0] core_addr,
   input wire logic [7:0] core_wdata,
   input wire logic [EVENT_W-1:0] usb_event,
   input wire logic flash_sel,
   input wire logic [19:0] flash_addr,
   input wire logic sfr_sel,
   input wire logic irq0
);
   // xdata wins the decode when both spaces ask at once
   wire logic xd = xdata_rd | xdata_wr;
   wire logic cd = code_rd & ~xd;
   wire logic [1:0] win = core_addr[15:14];
   wire logic clr = xdata_wr & (core_addr == 16'h7f30);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   low_code_a: assert property (cd && win == 2'h0 |=> flash_sel &&
      flash_addr == {4'h0, $past(core_addr)}) else $error("low code map");
   second_code_a: assert property (cd && win == 2'h1 |=> flash_sel &&
      flash_addr[13:0] == $past(core_addr[13:0])) else $error("second window");
   mid_window_a: assert property ((cd | xd) && win == 2'h2 |=> flash_sel &&
      flash_addr[13:0] == $past(core_addr[13:0])) else $error("mid window");
   top_alias_a: assert property ((cd | xd) && win == 2'h3 |=> flash_sel &&
      flash_addr[13:0] == $past(core_addr[13:0])) else $error("top window");
   xdata_low_a: assert property (xd && win == 2'h0 |=> sfr_sel && !flash_sel)
      else $error("low xdata");
   xdata_mid_a: assert property (xd && win == 2'h1 |=> !flash_sel && !sfr_sel)
      else $error("mid xdata");
   irq_set_a: assert property (usb_event[0] |=> irq0) else $error("irq set");
   irq_hold_a: assert property (irq0 && !clr |=> irq0) else $error("irq lost");
   irq_clear_a: assert property (clr && core_wdata == 8'hff && usb_event == '0
      |=> !irq0) else $error("irq clear");
endmodule

// ---- sim/mbw_core_model.sv ----
`timescale 1ns/1ns
// ==========================================
// core model: one access per call, idle between
module mbw_core_model (
   input wire logic clk,
   output logic code_rd,
   output logic xdata_rd,
   output logic xdata_wr,
   output logic [15:0] core_addr,
   output logic [7:0] core_wdata
);
   initial begin
      {code_rd, xdata_rd, xdata_wr} = 3'h0;
      core_addr = 16'h0;
      core_wdata = 8'h0;
   end
   // kind 0 code read, 1 xdata read, 2 xdata write
   task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      {code_rd, xdata_rd, xdata_wr} = {k == 2'h0, k == 2'h1, k == 2'h2};
      core_addr = a;
      core_wdata = d;
      @(posedge clk);
      @(negedge clk);
      // released bus shows the inverse so stale values never match
      {code_rd, xdata_rd, xdata_wr} = 3'h0;
      core_addr = ~a;
      core_wdata = ~d;
   endtask
endmodule

// ---- sim/tb_mbw_mapper.sv ----
`timescale 1ns/1ns
module tb_mbw_mapper;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic code_rd, xdata_rd, xdata_wr, access_valid, access_write, flash_sel, sfr_sel;
   logic periph_sel, io_sel, mem_sel, local_sel, irq0;
   logic [15:0] core_addr, periph_addr, io_addr;
   logic [7:0] core_wdata, local_rdata;
   logic [7:0] usb_event = 8'h00;
   logic [19:0] flash_addr, mem_addr;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   initial begin
      forever #25 clk = ~clk;
   end
   mbw_core_model i_mbw_core_model (.clk(clk), .code_rd(code_rd), .xdata_rd(xdata_rd),
      .xdata_wr(xdata_wr), .core_addr(core_addr), .core_wdata(core_wdata));
   mbw_mapper i_mbw_mapper (.clk(clk), .reset_n(reset_n), .code_rd(code_rd),
      .xdata_rd(xdata_rd), .xdata_wr(xdata_wr), .core_addr(core_addr),
      .core_wdata(core_wdata), .usb_event(usb_event), .access_valid(access_valid),
      .access_write(access_write), .flash_sel(flash_sel), .flash_addr(flash_addr),
      .sfr_sel(sfr_sel), .periph_sel(periph_sel), .periph_addr(periph_addr),
      .io_sel(io_sel), .io_addr(io_addr), .mem_sel(mem_sel), .mem_addr(mem_addr),
      .local_sel(local_sel), .local_rdata(local_rdata), .irq0(irq0));
   task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ax(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
      i_mbw_core_model.acc(k, a, d);
   endtask
   // both bank registers, then every flash window
   task automatic t_flash;
      ax(2'h2, 16'h7f28, 8'h05);
      chk("bank wr", {local_sel, access_write}, 20'h3);
      ax(2'h2, 16'h7f29, 8'h2a);
      ax(2'h1, 16'h7f28, 8'h00);
      chk("bank rd", local_rdata, 20'h05);
      ax(2'h0, 16'h1234, 8'h00);
      chk("low", flash_addr, 20'h01234);
      ax(2'h0, 16'h4321, 8'h00);
      chk("second", flash_addr, 20'ha8321);
      ax(2'h1, 16'h8123, 8'h00);
      chk("mid", flash_addr, 20'h14123);
      ax(2'h0, 16'hc321, 8'h00);
      chk("top", flash_addr, 20'ha8321);
   endtask
   // io window stays shut until its base is written
   task automatic t_xdata;
      ax(2'h1, 16'h0010, 8'h00);
      chk("sfr", {sfr_sel, flash_sel}, 20'h2);
      ax(2'h1, 16'h6000, 8'h00);
      chk("periph", {periph_sel, flash_sel}, 20'h2);
      chk("periph addr", periph_addr, 20'h06000);
      ax(2'h1, 16'h4010, 8'h00);
      chk("io off", {access_valid, io_sel}, 20'h2);
      ax(2'h2, 16'h7f71, 8'h3c);
      ax(2'h1, 16'h4010, 8'h00);
      chk("io on", {io_sel, io_addr}, 20'h13c10);
      ax(2'h2, 16'h7f72, 8'h9a);
      ax(2'h1, 16'h5abc, 8'h00);
      chk("mem sel", mem_sel, 20'h1);
      chk("mem addr", mem_addr, 20'h9aabc);
   endtask
   // two sources pending, polled twice, cleared one at a time
   task automatic t_irq;
      @(negedge clk) usb_event = 8'h05;
      @(negedge clk) usb_event = 8'h00;
      chk("irq", irq0, 20'h1);
      ax(2'h1, 16'h7f30, 8'h00);
      ax(2'h1, 16'h7f30, 8'h00);
      chk("poll", local_rdata, 20'h05);
      ax(2'h2, 16'h7f30, 8'h01);
      ax(2'h1, 16'h7f30, 8'h00);
      chk("one clr", local_rdata, 20'h04);
      ax(2'h2, 16'h7f30, 8'hff);
      chk("all clr", irq0, 20'h0);
      // an event in the cycle of its own clear must survive
      fork
         ax(2'h2, 16'h7f30, 8'h04);
         begin
            @(negedge clk) usb_event = 8'h04;
            @(negedge clk) usb_event = 8'h00;
         end
      join
      chk("set wins", irq0, 20'h1);
      ax(2'h2, 16'h7f30, 8'h04);
      chk("late clr", irq0, 20'h0);
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) reset_n = 1'b1;
      t_flash;
      t_xdata;
      t_irq;
      close_out;
   end
   // hang guard, far above the few dozen cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         close_out;
      end
   end
endmodule
bind mbw_mapper mbw_map_checker #(.EVENT_W(EVENT_W)) i_mbw_map_checker (.clk(clk),
   .reset_n(reset_n), .code_rd(code_rd), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
   .core_addr(core_addr), .core_wdata(core_wdata), .usb_event(usb_event),
   .flash_sel(flash_sel), .flash_addr(flash_addr), .sfr_sel(sfr_sel), .irq0(irq0));
